// [hw/ipv_pkg.sv]
package ipv_pkg;
    // Interrupt sources, listed in natural polling priority order.
    localparam int unsigned NUM_SOURCES = 10;
    localparam int unsigned SRC_W       = 4;
    localparam int unsigned PC_W        = 16;

    localparam logic [SRC_W-1:0] SRC_EXTERNAL_INTERRUPT_ZERO = 4'h0;
    localparam logic [SRC_W-1:0] SRC_TIMER0                  = 4'h1;
    localparam logic [SRC_W-1:0] SRC_EXTERNAL_INTERRUPT_ONE  = 4'h2;
    localparam logic [SRC_W-1:0] SRC_TIMER1                  = 4'h3;
    localparam logic [SRC_W-1:0] SRC_SERIAL_PORT_ONE         = 4'h4;
    localparam logic [SRC_W-1:0] SRC_TIMER2_EXTERNAL_FLAG    = 4'h5;
    localparam logic [SRC_W-1:0] SRC_USB                     = 4'h6;
    localparam logic [SRC_W-1:0] SRC_DISPLAY_DATA_CHANNEL    = 4'h7;
    localparam logic [SRC_W-1:0] SRC_I2C                     = 4'h8;
    localparam logic [SRC_W-1:0] SRC_SERIAL_PORT_TWO         = 4'h9;

    // Fixed service routine entry points, one per source index.
    localparam logic [PC_W-1:0] VECTOR_TABLE [NUM_SOURCES] = '{
        16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
        16'h002b, 16'h0033, 16'h003b, 16'h0043, 16'h004b
    };

    // One machine cycle is six states of two phases each; one phase per enabled clock.
    localparam int unsigned PHASE_W        = 4;
    localparam logic [PHASE_W-1:0] PHASES_PER_CYCLE = 4'hc;
    localparam logic [PHASE_W-1:0] PHASE_FIRST      = 4'h0;
    // State five, phase two is the ninth phase counted from zero.
    localparam logic [PHASE_W-1:0] PHASE_STATE_FIVE_PHASE_TWO = 4'h9;
    // State six, phase two closes the machine cycle.
    localparam logic [PHASE_W-1:0] PHASE_LAST       = 4'hb;
endpackage

// [hw/ipv_sampler.sv]
`timescale 1ns/1ps
module ipv_sampler #(
    parameter int unsigned N = ipv_pkg::NUM_SOURCES
) (
    input  wire logic                         i_clock,
    input  wire logic                         i_reset,
    input  wire logic                         i_clock_en,
    input  wire logic [N-1:0]                 i_flags,
    output logic      [ipv_pkg::PHASE_W-1:0]  o_phase,
    output logic      [N-1:0]                 o_polled
);
    import ipv_pkg::*;

    logic [PHASE_W-1:0] phase_r;
    logic [PHASE_W-1:0] phase_nxt;
    logic [N-1:0]       sample_r;
    logic [N-1:0]       sample_nxt;
    logic [N-1:0]       polled_r;
    logic [N-1:0]       polled_nxt;

    always_comb begin
        phase_nxt  = phase_r;
        sample_nxt = sample_r;
        polled_nxt = polled_r;
        if (i_clock_en) begin
            phase_nxt = (phase_r == PHASE_LAST) ? PHASE_FIRST : phase_r + 4'h1;
            if (phase_r == PHASE_STATE_FIVE_PHASE_TWO) begin
                sample_nxt = i_flags;
            end
            if (phase_r == PHASE_LAST) begin
                polled_nxt = sample_r;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            phase_r  <= PHASE_FIRST;
            sample_r <= '0;
            polled_r <= '0;
        end else begin
            phase_r  <= phase_nxt;
            sample_r <= sample_nxt;
            polled_r <= polled_nxt;
        end
    end

    assign o_phase  = phase_r;
    assign o_polled = polled_r;
endmodule // ipv_sampler

// [hw/ipv_pick.sv]
`timescale 1ns/1ps
module ipv_pick #(
    parameter int unsigned N = ipv_pkg::NUM_SOURCES
) (
    input  wire logic [N-1:0]               i_req,
    output logic                            o_found,
    output logic      [ipv_pkg::SRC_W-1:0]  o_index
);
    import ipv_pkg::*;

    logic [N:0]   taken;
    logic [N-1:0] first;

    assign taken[0] = 1'b0;

    // The lowest index wins, which is the fixed polling order.
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chain
            assign first[g]   = i_req[g] & ~taken[g];
            assign taken[g+1] = taken[g] | i_req[g];
        end
    endgenerate

    always_comb begin
        o_index = '0;
        for (int i = 0; i < N; i++) begin
            if (first[i]) begin
                o_index = o_index | SRC_W'(i);
            end
        end
    end

    assign o_found = taken[N];
endmodule // ipv_pick

// [hw/ipv_unit.sv]
// How it works
// - Sample all flags at state_five_phase_two.
// - Poll samples next cycle, then issue call.
// - Block while equal or higher level active.
// - Block unless final cycle of instruction.
// - Block during return or enable/priority access.
// - Poll every cycle, previous samples only.
// - Blocked requests are forgotten, never latched.
// - Call pushes counter only, loads vector.
// - All ten sources use fixed vectors.
// - Return-from-interrupt clears marking, pops counter.
// - Plain return leaves in-progress marking set.
`timescale 1ns/1ps
module ipv_unit #(
    parameter int unsigned N = ipv_pkg::NUM_SOURCES
) (
    input  wire logic                         i_clock,
    input  wire logic                         i_reset,
    input  wire logic                         i_clock_en,
    input  wire logic [N-1:0]                 i_flags,
    input  wire logic [N-1:0]                 i_source_enable,
    input  wire logic [N-1:0]                 i_source_high_priority,
    input  wire logic                         i_global_enable,
    input  wire logic                         i_last_cycle,
    input  wire logic                         i_instr_return_from_interrupt,
    input  wire logic                         i_instr_enable_priority_access,
    input  wire logic                         i_return_from_interrupt_done,
    input  wire logic                         i_plain_subroutine_return_done,
    output logic                              o_long_subroutine_call,
    output logic                              o_push_program_counter,
    output logic                              o_save_program_status_word,
    output logic      [ipv_pkg::PC_W-1:0]     o_vector,
    output logic      [ipv_pkg::SRC_W-1:0]    o_source,
    output logic                              o_pop_program_counter,
    output logic                              o_in_progress_low,
    output logic                              o_in_progress_high,
    output logic      [ipv_pkg::PHASE_W-1:0]  o_phase
);
    import ipv_pkg::*;

    logic [PHASE_W-1:0] phase;
    logic [N-1:0]       polled;
    logic [N-1:0]       req_high;
    logic [N-1:0]       req_low;
    logic               found_high;
    logic               found_low;
    logic [SRC_W-1:0]   index_high;
    logic [SRC_W-1:0]   index_low;
    logic               decide;
    logic               blocked_instr;

    logic               call_r;
    logic               call_nxt;
    logic [PC_W-1:0]    vector_r;
    logic [PC_W-1:0]    vector_nxt;
    logic [SRC_W-1:0]   source_r;
    logic [SRC_W-1:0]   source_nxt;
    logic               pop_r;
    logic               pop_nxt;
    logic               ip_low_r;
    logic               ip_low_nxt;
    logic               ip_high_r;
    logic               ip_high_nxt;
    logic [PHASE_W-1:0] phase_r;
    logic [PHASE_W-1:0] phase_nxt;
    logic               save_r;
    logic               save_nxt;

    ipv_sampler #(
        .N          (N)
    ) u_sampler (
        .i_clock    (i_clock),
        .i_reset    (i_reset),
        .i_clock_en (i_clock_en),
        .i_flags    (i_flags),
        .o_phase    (phase),
        .o_polled   (polled)
    );

    assign req_high = (ip_high_r) ? '0 : (polled & i_source_enable & i_source_high_priority);
    assign req_low  = (ip_high_r || ip_low_r) ? '0
                    : (polled & i_source_enable & ~i_source_high_priority);

    ipv_pick #(
        .N       (N)
    ) u_pick_high (
        .i_req   (req_high & {N{i_global_enable}}),
        .o_found (found_high),
        .o_index (index_high)
    );

    ipv_pick #(
        .N       (N)
    ) u_pick_low (
        .i_req   (req_low & {N{i_global_enable}}),
        .o_found (found_low),
        .o_index (index_low)
    );

    assign blocked_instr = i_instr_return_from_interrupt | i_instr_enable_priority_access;
    assign decide = i_clock_en && (phase == PHASE_LAST) && i_last_cycle && !blocked_instr;

    // The decision is taken once per machine cycle and nothing of a refused
    // request is kept, so a flag that drops while blocked is simply missed.
    always_comb begin
        call_nxt    = 1'b0;
        vector_nxt  = vector_r;
        source_nxt  = source_r;
        pop_nxt     = 1'b0;
        ip_low_nxt  = ip_low_r;
        ip_high_nxt = ip_high_r;
        phase_nxt   = phase_r;
        save_nxt    = 1'b0;
        if (!i_clock_en) begin
            call_nxt = call_r;
            pop_nxt  = pop_r;
        end else begin
            phase_nxt = phase;
            if (i_return_from_interrupt_done) begin
                pop_nxt = 1'b1;
                if (ip_high_r) begin
                    ip_high_nxt = 1'b0;
                end else begin
                    ip_low_nxt = 1'b0;
                end
            end
            if (i_plain_subroutine_return_done) begin
                pop_nxt = 1'b1;
            end
            if (decide && (found_high || found_low)) begin
                call_nxt = 1'b1;
                if (found_high) begin
                    source_nxt = index_high;
                    vector_nxt = VECTOR_TABLE[index_high];
                    ip_high_nxt = 1'b1;
                end else begin
                    source_nxt = index_low;
                    vector_nxt = VECTOR_TABLE[index_low];
                    ip_low_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            call_r    <= 1'b0;
            vector_r  <= '0;
            source_r  <= '0;
            pop_r     <= 1'b0;
            ip_low_r  <= 1'b0;
            ip_high_r <= 1'b0;
            phase_r   <= PHASE_FIRST;
            save_r    <= 1'b0;
        end else begin
            call_r    <= call_nxt;
            vector_r  <= vector_nxt;
            source_r  <= source_nxt;
            pop_r     <= pop_nxt;
            ip_low_r  <= ip_low_nxt;
            ip_high_r <= ip_high_nxt;
            phase_r   <= phase_nxt;
            save_r    <= save_nxt;
        end
    end

    assign o_long_subroutine_call     = call_r;
    assign o_push_program_counter     = call_r;
    assign o_save_program_status_word = save_r;
    assign o_vector                   = vector_r;
    assign o_source                   = source_r;
    assign o_pop_program_counter      = pop_r;
    assign o_in_progress_low          = ip_low_r;
    assign o_in_progress_high         = ip_high_r;
    assign o_phase                    = phase_r;
endmodule // ipv_unit

// [test/ipv_unit_properties.sv]
`timescale 1ns/1ps
module ipv_unit_properties
    import ipv_pkg::*;
#(
    parameter int unsigned N = ipv_pkg::NUM_SOURCES
) (
    input wire logic                       i_clock,
    input wire logic                       i_reset,
    input wire logic [N-1:0]               i_source_high_priority,
    input wire logic                       i_global_enable,
    input wire logic                       i_last_cycle,
    input wire logic                       i_instr_return_from_interrupt,
    input wire logic                       i_instr_enable_priority_access,
    input wire logic                       i_return_from_interrupt_done,
    input wire logic                       i_plain_subroutine_return_done,
    input wire logic                       o_long_subroutine_call,
    input wire logic                       o_push_program_counter,
    input wire logic                       o_save_program_status_word,
    input wire logic [ipv_pkg::PC_W-1:0]   o_vector,
    input wire logic [ipv_pkg::SRC_W-1:0]  o_source,
    input wire logic                       o_pop_program_counter,
    input wire logic                       o_in_progress_low,
    input wire logic                       o_in_progress_high,
    input wire logic [ipv_pkg::PHASE_W-1:0] o_phase
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    // The bench holds priorities steady across a call, so the present value is the decided one.
    wire hp_src = i_source_high_priority[o_source];
    sequence s_may_call;
        $past(i_last_cycle && i_global_enable && !i_instr_return_from_interrupt
              && !i_instr_enable_priority_access);
    endsequence
    sequence s_return;
        i_return_from_interrupt_done || i_plain_subroutine_return_done;
    endsequence
    a_call_on_last: assert property (o_long_subroutine_call |-> o_phase == PHASE_LAST)
        else $error("call outside closing phase");
    a_call_allowed: assert property (o_long_subroutine_call |-> s_may_call)
        else $error("call while blocked");
    a_level_block: assert property (
        o_long_subroutine_call && !$past(i_return_from_interrupt_done)
        |-> !$past(o_in_progress_high) && (hp_src || !$past(o_in_progress_low)))
        else $error("call over busy level");
    a_call_marks: assert property (o_long_subroutine_call |->
        (hp_src ? o_in_progress_high : o_in_progress_low))
        else $error("level not marked");
    a_call_pulse: assert property (o_long_subroutine_call |=> !o_long_subroutine_call)
        else $error("call longer than one clock");
    a_push_call: assert property (o_push_program_counter == o_long_subroutine_call)
        else $error("push differs from call");
    a_no_status_save: assert property (!o_save_program_status_word)
        else $error("status word saved");
    a_vector_src: assert property (o_long_subroutine_call |->
        o_vector == VECTOR_TABLE[o_source])
        else $error("wrong vector");
    a_pop_return: assert property (s_return |=> o_pop_program_counter)
        else $error("no pop after return");
    a_return_clears: assert property (
        i_return_from_interrupt_done && o_in_progress_high
        |=> !o_in_progress_high || o_long_subroutine_call)
        else $error("high marking kept");
    a_plain_keep: assert property (
        i_plain_subroutine_return_done && !i_return_from_interrupt_done && o_in_progress_low
        |=> o_in_progress_low)
        else $error("plain return cleared marking");
endmodule // ipv_unit_properties

bind ipv_unit ipv_unit_properties #(.N(N)) u_ipv_unit_properties (
    .i_clock(i_clock), .i_reset(i_reset), .i_source_high_priority(i_source_high_priority),
    .i_global_enable(i_global_enable), .i_last_cycle(i_last_cycle),
    .i_instr_return_from_interrupt(i_instr_return_from_interrupt),
    .i_instr_enable_priority_access(i_instr_enable_priority_access),
    .i_return_from_interrupt_done(i_return_from_interrupt_done),
    .i_plain_subroutine_return_done(i_plain_subroutine_return_done),
    .o_long_subroutine_call(o_long_subroutine_call), .o_vector(o_vector),
    .o_push_program_counter(o_push_program_counter), .o_source(o_source),
    .o_save_program_status_word(o_save_program_status_word), .o_phase(o_phase),
    .o_pop_program_counter(o_pop_program_counter), .o_in_progress_low(o_in_progress_low),
    .o_in_progress_high(o_in_progress_high));

// [test/ipv_sequencer_model.sv]
`timescale 1ns/1ps
module ipv_sequencer_model #(
    parameter int DELAY = 20
) (
    input  wire logic i_clock,
    input  wire logic i_reset,
    input  wire logic i_push,
    input  wire logic i_pop,
    input  wire logic i_use_plain,
    output logic      o_intr_return_done,
    output logic      o_plain_done,
    output int        o_depth
);
    int wait_cnt;
    // The service routine runs a while, then leaves by the return kind the bench asked for.
    always @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            o_intr_return_done <= 1'b0;
            o_plain_done <= 1'b0;
            o_depth <= 0;
            wait_cnt <= 0;
        end else begin
            o_intr_return_done <= wait_cnt == 1 && !i_use_plain;
            o_plain_done <= wait_cnt == 1 && i_use_plain;
            o_depth <= o_depth + int'(i_push) - int'(i_pop);
            wait_cnt <= i_push ? DELAY : (wait_cnt > 0 ? wait_cnt - 1 : 0);
        end
    end
endmodule // ipv_sequencer_model

// [test/ipv_unit_tb_top.sv]
`timescale 1ns/1ps
module ipv_unit_tb_top;
    import ipv_pkg::*;
    logic clk = 1'b0, rst = 1'b1, ge = 1'b1, lc = 1'b1, ri = 1'b0, ea = 1'b0, plain = 1'b0;
    logic ce = 1'b1;
    logic [9:0] fl = '0, en = '0, hp = '0;
    logic call, push, save, pop, lo, hi, rd, pd;
    logic [15:0] vec;
    logic [3:0] src, ph;
    logic [31:0] seed = 32'h2eb3b534;
    int depth, failures = 0, tests_run = 0, exp_q[$];
    always #20 clk = ~clk;
    ipv_unit u_ipv_unit (.i_clock(clk), .i_reset(rst), .i_clock_en(ce), .i_flags(fl),
        .i_source_enable(en), .i_source_high_priority(hp), .i_global_enable(ge),
        .i_last_cycle(lc), .i_instr_return_from_interrupt(ri),
        .i_instr_enable_priority_access(ea), .i_return_from_interrupt_done(rd),
        .i_plain_subroutine_return_done(pd), .o_long_subroutine_call(call),
        .o_push_program_counter(push), .o_save_program_status_word(save), .o_vector(vec),
        .o_source(src), .o_pop_program_counter(pop), .o_in_progress_low(lo),
        .o_in_progress_high(hi), .o_phase(ph));
    ipv_sequencer_model u_ipv_sequencer_model (.i_clock(clk), .i_reset(rst), .i_push(push),
        .i_pop(pop), .i_use_plain(plain), .o_intr_return_done(rd), .o_plain_done(pd),
        .o_depth(depth));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic int pick(input logic [9:0] r, input logic [9:0] h, input logic lb,
                                input logic hb);
        if (hb) return -1;
        for (int i = 0; i < 10; i++) if (r[i] && h[i]) return i;
        if (!lb) for (int i = 0; i < 10; i++) if (r[i]) return i;
        return -1;
    endfunction
    task automatic compare(input string what, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Flags stand 13 clocks so at least one sample lands; blocks outlast the polling of it.
    task automatic run(input logic [9:0] f, e, h, input logic [3:0] blk, input logic lb, hb);
        int s;
        logic [3:0] p;
        s = (blk == 0) ? pick(f & e, h, lb, hb) : -1;
        if (s >= 0) exp_q.push_back(s);
        @(posedge clk);
        fl <= f;
        en <= e;
        hp <= h;
        {ea, ri} <= blk[3:2];
        {lc, ge} <= ~blk[1:0];
        repeat (13) @(posedge clk);
        fl <= '0;
        repeat (30) @(posedge clk);
        {ea, ri, lc, ge} <= 4'h3;
        repeat (40) @(posedge clk);
        // A quiet pause with the enable low: the phase must stand still.
        ce <= 1'b0;
        @(negedge clk);
        p = ph;
        repeat (4) @(negedge clk);
        compare("frozen phase", 16'(p), 16'(ph));
        @(posedge clk);
        ce <= 1'b1;
        compare("missing calls", 16'h0000, 16'(exp_q.size()));
        compare("high level clear", 16'h0000, 16'(hi));
        compare("stack depth", 16'h0000, 16'(depth));
        $display("test with flags %h done", f);
    endtask
    always @(negedge clk) begin
        if (call === 1'b1) begin
            if (exp_q.size() == 0) compare("unexpected call", 16'h0000, 16'h0001);
            else begin
                compare("source", 16'(exp_q[0]), 16'(src));
                compare("level mark", 16'h0001, 16'(hp[exp_q[0]] ? hi : lo));
                compare("call phase", 16'(PHASE_LAST), 16'(ph));
                compare("status word save", 16'h0000, 16'(save));
                compare("vector", VECTOR_TABLE[exp_q.pop_front()], vec);
            end
        end
    end
    initial begin
        repeat (120 * 40) @(posedge clk);
        failures++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) run(10'h001 << i, '1, 10'(i % 2) << i, 0, 0, 0);
        for (int b = 0; b < 4; b++) run(10'h3ff, '1, '1, 4'h1 << b, 0, 0);
        repeat (12) begin
            seed = xs(seed);
            run(seed[9:0], seed[19:10] | seed[9:0], seed[29:20], 0, 0, 0);
        end
        plain <= 1'b1;
        run(10'h004, '1, '0, 0, 0, 0);
        compare("low level kept", 16'h0001, 16'(lo));
        plain <= 1'b0;
        run(10'h001, '1, '0, 0, 1, 0);
        run(10'h011, '1, 10'h010, 0, 1, 0);
        run(10'h002, '1, '0, 0, 1, 0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        run(10'h001, '1, '0, 0, 0, 0);
        final_report();
    end
endmodule // ipv_unit_tb_top
